// ==== hdl/node_diag_pkg.sv ====
package node_diag_pkg;
  // Register byte offsets within one node's block, and top words within the bank
  localparam logic [7:0]  OFF_COUNT    = 8'h00;  // Entry count
  localparam logic [7:0]  OFF_FLAGS    = 8'h04;  // Diagnostic flags
  localparam logic [7:0]  OFF_MISSING  = 8'h08;  // Missing transmit PDO bits
  localparam logic [7:0]  OFF_EMCNT    = 8'h0C;  // Stored emergency count
  localparam logic [7:0]  OFF_IRQSTAT  = 8'hF0;  // Interrupt status
  localparam logic [7:0]  OFF_IRQEN    = 8'hF4;  // Interrupt enable
  localparam logic [7:0]  OFF_IRQCLR   = 8'hF8;  // Interrupt clear, write only
  localparam logic [7:0]  OFF_EMPOP    = 8'hFC;  // Emergency pop, write only
  localparam int          NODE_SHIFT   = 4;      // Sixteen bytes per node
  localparam int          OFF_WIDTH    = 8;      // Byte offset bits below the bank select
  // Field positions
  localparam int          FLAG_HB      = 0;      // Heartbeat refused
  localparam int          FLAG_BOOT    = 1;      // Bad boot-up
  localparam int          FLAG_EMOVF   = 2;      // Emergency overflow
  localparam int          FLAG_USED    = 3;      // Implemented flag bits
  localparam int          PDO_DIRECT   = 15;     // Individually tracked PDOs
  localparam int          PDO_OTHER    = 15;     // Bit for all others
  localparam logic [7:0]  ENTRY_COUNT  = 8'h02;  // Subentries per node
  localparam int          EMCY_DEPTH   = 10;     // Emergency store depth
  // Pending-state encoding
  typedef enum logic [0:0] {
    PDO_SEEN    = 1'b0,
    PDO_PENDING = 1'b1
  } pdo_state_e;
endpackage : node_diag_pkg

// ==== hdl/node_diag_slot.sv ====
`timescale 1ns/10ps
// One node's diagnostic state
module node_diag_slot #(
  parameter int NUM_PDO = 32
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               clkEn,
  // Node events
  input  wire logic               nodeStart,
  input  wire logic               hbRefused,
  input  wire logic               badBoot,
  input  wire logic               emcyIn,
  input  wire logic               emcyPop,
  input  wire logic [NUM_PDO-1:0] pdoConfigured,
  input  wire logic [NUM_PDO-1:0] pdoRx,
  // State out
  output logic      [15:0]        flags,
  output logic      [15:0]        missing,
  output logic      [3:0]         emcyCount,
  output logic                    emcyOverflowEvt
);
  logic [NUM_PDO-1:0] pending;      // Per PDO pending bits
  logic [node_diag_pkg::FLAG_USED-1:0] flagBits; // Implemented sticky flag bits
  logic               emcyFull;     // Store holds ten
  logic               others;       // Any high PDO pending
  logic [3:0]         next_count;   // Next emergency count

  assign emcyFull        = (emcyCount == 4'(node_diag_pkg::EMCY_DEPTH));
  assign emcyOverflowEvt = emcyIn & emcyFull & clkEn;
  assign others          = |(pending >> node_diag_pkg::PDO_DIRECT);
  assign missing         = {others, pending[node_diag_pkg::PDO_DIRECT-1:0]};
  assign flags = 16'(flagBits);
  // Count moves up on accepted arrival, down on pop
  assign next_count = emcyCount + 4'((emcyIn & ~emcyFull) ? 1 : 0) - 4'((emcyPop && emcyCount != 4'h0) ? 1 : 0);

  // Pending bits: armed at start, cleared on first reception
  genvar k;
  for (k = 0; k < NUM_PDO; k++) begin : g_pdo
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        pending[k] <= node_diag_pkg::PDO_SEEN;
      end else if (clkEn) begin
        if (nodeStart) begin
          pending[k] <= pdoConfigured[k] ? node_diag_pkg::PDO_PENDING : node_diag_pkg::PDO_SEEN;
        end else if (pdoRx[k]) begin
          pending[k] <= node_diag_pkg::PDO_SEEN;
        end
      end
    end
  end

  // Sticky flags and emergency count; flags clear only at reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flagBits                            <= '0;
      emcyCount                           <= '0;
    end else if (clkEn) begin
      emcyCount <= next_count;
      if (hbRefused) begin
        flagBits[node_diag_pkg::FLAG_HB] <= 1'b1;
      end
      if (badBoot) begin
        flagBits[node_diag_pkg::FLAG_BOOT] <= 1'b1;
      end
      if (emcyIn && emcyFull) begin
        flagBits[node_diag_pkg::FLAG_EMOVF] <= 1'b1;
      end
    end
  end
endmodule : node_diag_slot

// ==== hdl/can_node_diagnosis_status.sv ====
`timescale 1ns/10ps
// Diagnostic register bank for all configured nodes, APB slave
module can_node_diagnosis_status #(
  parameter int NUM_NODES = 4,
  parameter int NUM_PDO   = 32
) (
  // Clock, reset, enable
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic                           clkEn,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Node events, one bit per node; the PDO inputs carry NUM_PDO bits per node
  input  wire logic [NUM_NODES-1:0]           nodeConfigured,
  input  wire logic [NUM_NODES-1:0]           nodeStart,
  input  wire logic [NUM_NODES-1:0]           hbRefused,
  input  wire logic [NUM_NODES-1:0]           badBoot,
  input  wire logic [NUM_NODES-1:0]           emcyIn,
  input  wire logic [NUM_NODES*NUM_PDO-1:0]   pdoConfigured,
  input  wire logic [NUM_NODES*NUM_PDO-1:0]   pdoRx,
  // Interrupt
  output logic                                irq
);

  // Address map, byte addresses inside the lowest bank
  //   Node n entry occupies sixteen bytes starting at n times sixteen
  //   +0 subentry count, reads as a constant
  //   +4 diagnostic flags, bits above the event bits read zero
  //   +8 missing transmit PDO word
  //   +C number of stored emergencies
  //   Top word F0 interrupt status, read only
  //   Top word F4 interrupt enable, read and write
  //   Top word F8 interrupt clear, write ones, read refused
  //   Top word FC emergency pop, write ones, read refused
  // Node numbers stay below fifteen, so node entries never meet the globals
  // Any other address, or an unconfigured node, answers with an error

  // Address split widths
  localparam int NODE_BITS = $clog2(NUM_NODES) > 0 ? $clog2(NUM_NODES) : 1; // Node index width
  localparam int OFF_W     = node_diag_pkg::OFF_WIDTH;                        // Offset bits inside the bank
  localparam int SUB_W     = node_diag_pkg::NODE_SHIFT;                       // Offset bits inside one node
  localparam int IDX_W     = OFF_W - SUB_W;                                   // Node field width

  // Per-node state gathered from the slots, and strobes sent to them
  logic [15:0]          flags     [NUM_NODES];  // Per node flags
  logic [15:0]          missing   [NUM_NODES];  // Per node missing bits
  logic [3:0]           emcyCount [NUM_NODES];  // Per node store fill
  logic [NUM_NODES-1:0] emcyOvf;                // Overflow events
  logic [NUM_NODES-1:0] emcyPop;                // Pop strobes
  logic [NUM_NODES-1:0] hbStart;                // Start issued with heartbeat refused

  // Interrupt state
  logic [NUM_NODES-1:0] irqStatus;              // Sticky event bits
  logic [NUM_NODES-1:0] irqEnable;              // Interrupt enables
  logic [NUM_NODES-1:0] irqClear;               // Clear strobes
  logic [NUM_NODES-1:0] irqEvent;               // New heartbeat, boot or overflow event
  logic [NUM_NODES-1:0] next_irqStatus;         // Status after this edge
  logic                 next_irq;               // Interrupt level after this edge

  // Bus phase decode
  // The access strobes carry clkEn and every register waits for it, so a frozen block neither answers nor
  // changes state; a setup edge lost to the freeze leaves the transfer with no answer at all
  wire                 setupPhase = psel & ~penable & ~pready;  // First cycle of a transfer
  wire                 access     = psel & penable & clkEn;     // Access phase on a live edge
  wire                 wrAccess   = access & pwrite;            // Write access phase
  wire                 wrDone     = wrAccess & pready;          // Edge at which a write lands

  // Address split
  wire [OFF_W-1:0]     regOff     = paddr[OFF_W-1:0];                 // Offset inside the bank
  wire                 bankZero   = paddr[$bits(paddr)-1:OFF_W] == '0; // Only the lowest bank is mapped
  wire [IDX_W-1:0]     nodeField  = paddr[OFF_W-1:SUB_W];             // Raw node number
  wire [NODE_BITS-1:0] nodeIdx    = NODE_BITS'(nodeField);            // Node number as an index
  wire [SUB_W-1:0]     subOff     = paddr[SUB_W-1:0];                 // Offset inside one node

  // Node entry decode
  wire                 nodeInRange = 32'(nodeField) < NUM_NODES;                           // Existing slot
  wire                 nodeOk      = bankZero && nodeInRange && nodeConfigured[nodeIdx];
  wire                 isCount     = nodeOk && subOff == node_diag_pkg::OFF_COUNT[SUB_W-1:0];
  wire                 isFlags     = nodeOk && subOff == node_diag_pkg::OFF_FLAGS[SUB_W-1:0];
  wire                 isMissing   = nodeOk && subOff == node_diag_pkg::OFF_MISSING[SUB_W-1:0];
  wire                 isEmCnt     = nodeOk && subOff == node_diag_pkg::OFF_EMCNT[SUB_W-1:0];

  // Global register decode
  wire                 isStat      = bankZero && regOff == node_diag_pkg::OFF_IRQSTAT;
  wire                 isEn        = bankZero && regOff == node_diag_pkg::OFF_IRQEN;
  wire                 isClr       = bankZero && regOff == node_diag_pkg::OFF_IRQCLR;
  wire                 isPop       = bankZero && regOff == node_diag_pkg::OFF_EMPOP;

  // Legal accesses: node entries read only, clear and pop write only
  wire                 rdOk        = isCount | isFlags | isMissing | isEmCnt | isStat | isEn;
  wire                 wrOk        = isEn | isClr | isPop;
  wire                 badAcc      = pwrite ? ~wrOk : ~rdOk;                                   // Refused access

  // Read words, zero above each field
  // Constant subentry count
  wire [31:0]          countWord   = 32'(node_diag_pkg::ENTRY_COUNT);
  // Flags of the addressed node
  wire [31:0]          flagsWord   = 32'(flags[nodeIdx]);
  // Missing transmit PDO bits of the addressed node
  wire [31:0]          missWord    = 32'(missing[nodeIdx]);
  // Stored emergencies of the addressed node
  wire [31:0]          emcyWord    = 32'(emcyCount[nodeIdx]);
  // Interrupt status bits
  wire [31:0]          statWord    = 32'(irqStatus);
  // Interrupt enable bits
  wire [31:0]          enWord      = 32'(irqEnable);

  // Read selection; refused reads return zero
  wire [31:0]          rdMux       = isCount   ? countWord
                                   : isFlags   ? flagsWord
                                   : isMissing ? missWord
                                   : isEmCnt   ? emcyWord
                                   : isStat    ? statWord
                                   : isEn      ? enWord
                                   : 32'h00000000;

  // Next answer values, taken at the setup edge
  wire                 next_pready  = setupPhase;                                  // One answer per setup
  wire                 next_pslverr = setupPhase & badAcc;
  wire [31:0]          next_prdata  = (setupPhase & ~pwrite) ? rdMux : 32'h00000000; // Data only on reads

  // Write strobes, live only at the edge that completes the write
  assign irqClear = (wrDone && isClr) ? pwdata[NUM_NODES-1:0] : '0;
  // Each set bit removes one stored emergency of that node
  assign emcyPop  = (wrDone && isPop) ? pwdata[NUM_NODES-1:0] : '0;

  // Node events that reach the interrupt status
  // Heartbeat refusal only counts at the start command
  assign hbStart        = hbRefused & nodeStart;
  // Overflow events already carry the clock enable
  assign irqEvent       = (clkEn ? (hbStart | badBoot) : '0) | emcyOvf;
  // A new event wins over a clear in the same cycle
  assign next_irqStatus = (irqStatus & ~irqClear) | irqEvent;
  // Level follows the status that this edge stores
  assign next_irq       = |(next_irqStatus & irqEnable);

  // Per-node state
  genvar n;
  for (n = 0; n < NUM_NODES; n++) begin : g_node
    node_diag_slot #(.NUM_PDO(NUM_PDO)) u_slot (
      // Clock and enable
      .clk             (clk),
      .rst_b           (rst_b),
      .clkEn           (clkEn),
      // Events from the bus side
      .nodeStart       (nodeStart[n]),
      .hbRefused       (hbStart[n]),
      .badBoot         (badBoot[n]),
      .emcyIn          (emcyIn[n]),
      .emcyPop         (emcyPop[n]),
      .pdoConfigured   (pdoConfigured[n*NUM_PDO +: NUM_PDO]),
      .pdoRx           (pdoRx[n*NUM_PDO +: NUM_PDO]),
      // State back to the bank
      .flags           (flags[n]),
      .missing         (missing[n]),
      .emcyCount       (emcyCount[n]),
      .emcyOverflowEvt (emcyOvf[n])
    );
  end

  // Bus answer: registered, no wait states after the setup cycle
  // The answer stands one cycle; the master releases the request at the
  // edge where it sees pready, so pready never meets a second access phase

  // Answer strobe: high for the one cycle after a setup
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else if (clkEn) begin
      pready <= next_pready;
    end
  end

  // Error flag: stands beside the answer strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pslverr <= next_pslverr;
    end
  end

  // Read data: zero whenever no read answer stands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (clkEn) begin
      prdata <= next_prdata;
    end
  end

  // Interrupt side
  // Status bits are sticky until written with ones to the clear word,
  // and the enable word only masks the level output

  // Enable register, written only at the completing edge of a legal write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqEnable <= '0;
    end else if (wrDone && isEn) begin
      irqEnable <= pwdata[NUM_NODES-1:0];
    end
  end

  // Sticky status: new event wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus <= '0;
    end else if (clkEn) begin
      irqStatus <= next_irqStatus;
    end
  end

  // Level interrupt, rises at the same edge as the status bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (clkEn) begin
      irq <= next_irq;
    end
  end
endmodule : can_node_diagnosis_status

// ==== tb/can_node_diagnosis_status_asserts.sv ====
`timescale 1ns/10ps
// Port-level checker for the diagnostic bank
module can_node_diagnosis_status_asserts #(
  parameter int NUM_NODES = 4,
  parameter int NUM_PDO   = 32
) (
  // All top ports, watched only
  input wire logic clk, rst_b, clkEn, psel, penable, pwrite, pready, pslverr, irq,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [NUM_NODES-1:0] nodeConfigured, nodeStart, hbRefused, badBoot, emcyIn,
  input wire logic [NUM_NODES*NUM_PDO-1:0] pdoConfigured, pdoRx
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Setup cycle on a live edge, and a read setup aimed at a node entry
  wire setup = psel && !penable && clkEn;
  wire nodeRd = setup && !pwrite && paddr < 12'h0F0;
  chk_ready_follows: assert property (setup |=> pready) else $error("no answer after setup");
  chk_ready_single: assert property (pready |=> !pready) else $error("answer held too long");
  chk_idle_quiet: assert property (!psel |=> !pready) else $error("answer without request");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  chk_count_value: assert property (nodeRd && paddr[3:0] == 4'h0 |=> pslverr || prdata == 32'h2)
    else $error("entry count wrong");
  chk_flags_reserved: assert property (nodeRd && paddr[3:0] == 4'h4 |=> prdata[31:3] == 29'h0)
    else $error("reserved flag bits set");
  chk_missing_upper: assert property (nodeRd && paddr[3:0] == 4'h8 |=> prdata[31:16] == 16'h0)
    else $error("missing word too wide");
  chk_write_refused: assert property (setup && pwrite && paddr < 12'h0F0 |=> pready && pslverr)
    else $error("write to node entry accepted");
  // Main scenarios reached
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property (pready && prdata[2]);
endmodule : can_node_diagnosis_status_asserts

bind can_node_diagnosis_status can_node_diagnosis_status_asserts #(.NUM_NODES(NUM_NODES), .NUM_PDO(NUM_PDO)) u_chk (
  .clk, .rst_b, .clkEn, .psel, .penable, .pwrite, .pready, .pslverr, .irq, .paddr, .pwdata, .prdata,
  .nodeConfigured, .nodeStart, .hbRefused, .badBoot, .emcyIn, .pdoConfigured, .pdoRx);

// ==== tb/can_slave_model.sv ====
`timescale 1ns/10ps
// Slave nodes on the bus, as seen by the master's event logic
module can_slave_model #(
  parameter int N = 2,
  parameter int P = 20
) (
  input  wire logic        clk,
  output logic [N-1:0]     nodeStart, hbRefused, badBoot, emcyIn,
  output logic [N*P-1:0]   pdoRx
);
  // Quiet bus at time zero
  initial begin
    nodeStart = '0;
    hbRefused = '0;
    badBoot = '0;
    emcyIn = '0;
    pdoRx = '0;
  end
  // One event pulse: 0 start, 1 boot-up fault, 2 emergency, 3 transmit PDO k+1
  task automatic fire(input int sel, input int n, input int k, input logic hb);
    @(posedge clk);
    case (sel)
      0: begin
        nodeStart[n] <= 1'b1;
        // Configurer picked heartbeat instead of guarding
        hbRefused[n] <= hb;
      end
      1: badBoot[n] <= 1'b1;
      2: emcyIn[n] <= 1'b1;
      default: pdoRx[n*P+k] <= 1'b1;
    endcase
    @(posedge clk);
    nodeStart <= '0;
    badBoot <= '0;
    emcyIn <= '0;
    pdoRx <= '0;
  endtask : fire
endmodule : can_slave_model

// ==== tb/tb_can_node_diagnosis_status.sv ====
`timescale 1ns/10ps
module tb_can_node_diagnosis_status;
  localparam int N = 2;
  localparam int P = 20;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, clkEn = 1, pready, pslverr, irq, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [N-1:0] nodeStart, hbRefused, badBoot, emcyIn;
  logic [N*P-1:0] pdoRx;
  int err_count = 0, num_checks = 0;
  // Table row: direction, address, write data, read data, error
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_s;
  row_s rows[8] = '{'{0, 12'h000, 0, 2, 0}, '{0, 12'h004, 0, 0, 0}, '{0, 12'h008, 0, 0, 0},
    '{0, 12'h010, 0, 0, 1}, '{1, 12'h004, 32'hFFFF, 0, 1}, '{0, 12'h0F8, 0, 0, 1},
    '{1, 12'h0F4, 1, 0, 0}, '{0, 12'h0F4, 0, 1, 0}};
  can_node_diagnosis_status #(.NUM_NODES(N), .NUM_PDO(P)) dut_u (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nodeConfigured(2'b01), .nodeStart(nodeStart),
    .hbRefused(hbRefused), .badBoot(badBoot), .emcyIn(emcyIn), .pdoConfigured({20'h0, 20'hFFFFF}),
    .pdoRx(pdoRx), .irq(irq));
  can_slave_model #(.N(N), .P(P)) m (.clk(clk), .nodeStart(nodeStart), .hbRefused(hbRefused),
    .badBoot(badBoot), .emcyIn(emcyIn), .pdoRx(pdoRx));
  // Free-running clock
  initial forever #5 clk = ~clk;
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Compare error bit and word
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  // Read and compare, no error expected
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rd, er);
    chk({er, rd}, {1'b0, x});
  endtask : rdchk
  // Verdict and end of run
  task automatic summarize;
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Watchdog
  initial begin
    #100000;
    err_count++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk({er, rd}, {rows[i].e, rows[i].r});
    end
    m.fire(0, 0, 0, 1'b1);
    rdchk(12'h004, 32'h1);
    rdchk(12'h008, 32'hFFFF);
    chk({32'h0, irq}, 33'h1);
    m.fire(3, 0, 0, 1'b0);
    m.fire(3, 0, 13, 1'b0);
    for (int k = 15; k < P; k++) m.fire(3, 0, k, 1'b0);
    rdchk(12'h008, 32'h5FFE);
    m.fire(1, 0, 0, 1'b0);
    rdchk(12'h004, 32'h3);
    repeat (11) m.fire(2, 0, 0, 1'b0);
    rdchk(12'h00C, 32'hA);
    rdchk(12'h004, 32'h7);
    apb(1'b1, 12'h0FC, 32'h1, rd, er);
    rdchk(12'h00C, 32'h9);
    apb(1'b1, 12'h0F8, 32'h1, rd, er);
    rdchk(12'h0F0, 32'h0);
    chk({32'h0, irq}, 33'h0);
    apb(1'b1, 12'h0F4, 32'h0, rd, er);
    m.fire(1, 0, 0, 1'b0);
    rdchk(12'h0F0, 32'h1);
    chk({32'h0, irq}, 33'h0);
    m.fire(0, 0, 0, 1'b0);
    rdchk(12'h008, 32'hFFFF);
    // Frozen block ignores an emergency, then counts one when live
    clkEn <= 1'b0;
    m.fire(2, 0, 0, 1'b0);
    clkEn <= 1'b1;
    rdchk(12'h00C, 32'h9);
    m.fire(2, 0, 0, 1'b0);
    rdchk(12'h00C, 32'hA);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rdchk(12'h004, 32'h0);
    summarize();
  end
endmodule : tb_can_node_diagnosis_status
